// ### rtl/tcc_consts.svh
// Register map, field positions and reset values of the compare/capture block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Channel count and the first channel that owns buffer registers
`define TCC_NCH 5
`define TCC_FIRST_BUF_CH 3
`define TCC_EXT_CLKS 4

// Word index layout: channel in index bits 4:2, register in bits 1:0
`define TCC_SEL_GRA 2'h0
`define TCC_SEL_GRB 2'h1
`define TCC_SEL_TCR 2'h2
// Buffer bank: channel field value 5, slot = {channel is 4, register B}
`define TCC_BUF_BANK 3'h5

// Reset values
`define TCC_WORD_RESET 16'hffff
`define TCC_TCR_RESET 8'h80

// Counter control field positions
`define TCC_CCLR_HI 6
`define TCC_CCLR_LO 5
`define TCC_CKEG_HI 4
`define TCC_CKEG_LO 3
`define TCC_TPSC_HI 2
`define TCC_TPSC_LO 0

// I/O select codes for compare use
`define TCC_IO_OUT0 3'h1
`define TCC_IO_OUT1 3'h2
`define TCC_IO_TOGGLE 3'h3
// Channel whose toggle code drives a steady high level
`define TCC_STEADY_CH 2

`endif

// ### rtl/tcc_pkg.sv
// Types and helper functions shared by the compare/capture block
package tcc_pkg;

    // Data word of the register port
    typedef logic [15:0] tcc_word_t;

    // Counter clear source selection
    typedef enum logic [1:0] {
        TCC_CLR_NONE = 2'b00,
        TCC_CLR_A = 2'b01,
        TCC_CLR_B = 2'b10,
        TCC_CLR_SYNC = 2'b11
    } tcc_clr_e;

    // One processor request; read when sel is high and wr is low
    typedef struct packed {
        logic sel;
        logic wr;
        logic [4:0] idx;
        logic [1:0] be;
        tcc_word_t wdata;
    } tcc_bus_s;

    // Buffer enables, in buffer slot order
    typedef struct packed {
        logic buffer_en_b_ch4;
        logic buffer_en_a_ch4;
        logic buffer_en_b_ch3;
        logic buffer_en_a_ch3;
    } tcc_fn_s;

    // All state of the top module
    typedef struct packed {
        logic [4:0][1:0][15:0] gr;
        logic [3:0][15:0] br;
        logic [4:0][7:0] counter_control;
        logic [4:0][1:0] lvl;
        logic [4:0][1:0] prev;
        logic [4:0][1:0] flag;
        logic [4:0] clr;
        tcc_word_t rdata;
        logic rvalid;
    } tcc_state_s;

    // Byte-lane merge of a write into a 16-bit register
    function automatic tcc_word_t tcc_merge(tcc_word_t old, tcc_word_t wd, logic [1:0] be);
        tcc_word_t res;
        res = old;
        if (be[1]) res[15:8] = wd[15:8];
        if (be[0]) res[7:0] = wd[7:0];
        return res;
    endfunction : tcc_merge

    // Edge choice: 00 rising, 01 falling, 1x both
    function automatic logic tcc_edge_hit(logic [1:0] sel, logic rise, logic fall);
        return sel[1] ? (rise | fall) : (sel[0] ? fall : rise);
    endfunction : tcc_edge_hit

endpackage : tcc_pkg

// ### rtl/tcc_sync.sv
// Three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/100ps
module tcc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Asynchronous inputs and their settled levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // All synchroniser state
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } tcc_sync_state_s;

    tcc_sync_state_s q, d;

    // Stage one feeds only stage two; the level follows agreement of two and three
    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.lvl;

endmodule : tcc_sync

// ### rtl/tcc_clock_sel.sv
// Counter clock selection: internal prescaler taps or edges of external clocks
`timescale 1ns/100ps
`include "tcc_consts.svh"
module tcc_clock_sel
    import tcc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Channel control byte and settled external clock levels
    input wire logic [7:0] ctrl,
    input wire logic [`TCC_EXT_CLKS-1:0] ext_lvl,
    input wire logic phase_mode,
    // One-cycle count request to the channel counter
    output logic count_tick
);
    // All state of the selector
    typedef struct packed {
        logic [2:0] div;
        logic [`TCC_EXT_CLKS-1:0] ext_prev;
        logic tick;
    } tcc_clk_state_s;

    tcc_clk_state_s q, d;
    logic [2:0] psc; // Prescaler field
    logic [1:0] edge_sel; // External edge field
    logic [2:0] mask; // Divider bits that must all be high
    logic rise; // Rising edge on the chosen external clock
    logic fall; // Falling edge on the chosen external clock

    // Count request generation
    always_comb begin
        d = q;
        psc = ctrl[`TCC_TPSC_HI:`TCC_TPSC_LO];
        edge_sel = ctrl[`TCC_CKEG_HI:`TCC_CKEG_LO];
        rise = 1'b0;
        fall = 1'b0;
        d.div = q.div + 3'h1;
        d.ext_prev = ext_lvl;
        unique case (psc[1:0])
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            2'h3: mask = 3'h7;
        endcase
        if (!psc[2]) begin
            // Internal source: one count request per divided period, edge field unused
            d.tick = (q.div & mask) == mask;
        end else begin
            // External source: edge field picks the counted edges
            rise = ext_lvl[psc[1:0]] && !q.ext_prev[psc[1:0]];
            fall = !ext_lvl[psc[1:0]] && q.ext_prev[psc[1:0]];
            d.tick = tcc_edge_hit(edge_sel, rise, fall);
        end
        // Phase counting takes over the counter, so these fields are ignored
        if (phase_mode) begin
            d.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count_tick = q.tick;

endmodule : tcc_clock_sel

// ### rtl/tcc_top.sv
// Compare/capture registers, buffer registers and counter control for five channels
`timescale 1ns/100ps
`include "tcc_consts.svh"

module tcc_top
    import tcc_pkg::*;
(
    // Clock, reset and low-power state
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic standby,
    // Processor register port
    input wire tcc_bus_s cpu_req,
    output logic [15:0] cpu_rdata,
    output logic cpu_rvalid,
    // Counter values and their step strobes
    input wire tcc_word_t [4:0] chan_counter,
    input wire logic [4:0] counter_step,
    // Mode settings from neighbouring timer registers
    input wire logic [4:0][1:0][2:0] io_sel,
    input wire logic [4:0] pwm_mode,
    input wire logic phase_mode_ch2,
    input wire tcc_fn_s function_control,
    input wire logic [4:0] sync_clear_in,
    // Compare/capture pins, index [channel][0 = A, 1 = B]
    input wire logic [4:0][1:0] pin_in,
    output logic [4:0][1:0] pin_out,
    output logic [4:0][1:0] pin_oe,
    // External clock pins, A in bit 0
    input wire logic [`TCC_EXT_CLKS-1:0] ext_clock_in,
    // Results to the counter and status logic
    output logic [4:0][1:0] match_flag_set,
    output logic [4:0] counter_clear,
    output logic [4:0] count_tick
);
    // State after reset and throughout standby
    localparam tcc_state_s ST_RST = '{
        gr: {10{`TCC_WORD_RESET}},
        br: {4{`TCC_WORD_RESET}},
        counter_control: {5{`TCC_TCR_RESET}},
        default: '0
    };

    tcc_state_s q, d;
    logic [4:0][1:0] pin_lvl; // Settled pin levels
    logic [`TCC_EXT_CLKS-1:0] ext_lvl; // Settled external clock levels
    logic [4:0][1:0] cmp; // Compare match this cycle
    logic [4:0][1:0] cap; // Capture this cycle
    logic [2:0] ch_idx; // Channel field of the request index
    logic [1:0] reg_sel; // Register field of the request index
    logic [2:0] io; // I/O select of the register in hand
    logic rise; // Rising edge on its pin
    logic fall; // Falling edge on its pin
    logic [1:0] bsel; // Buffer slot paired with it
    logic buf_on; // Buffering active for it

    assign ch_idx = cpu_req.idx[4:2];
    assign reg_sel = cpu_req.idx[1:0];

    // Pin and external clock synchroniser
    tcc_sync #(
        .W(10 + `TCC_EXT_CLKS)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .din({ext_clock_in, pin_in}),
        .dout({ext_lvl, pin_lvl})
    );

    // Counter clock selection per channel
    for (genvar c = 0; c < `TCC_NCH; c++) begin : g_clk
        tcc_clock_sel u_clk (
            .mclk(mclk),
            .rst_n(rst_n),
            .ctrl(q.counter_control[c]),
            .ext_lvl(ext_lvl),
            .phase_mode(phase_mode_ch2 && (c == 2)),
            .count_tick(count_tick[c])
        );
    end

    // Next state: processor access first, hardware events override it
    always_comb begin
        d = q;
        d.flag = '0;
        d.clr = '0;
        d.rvalid = 1'b0;
        cmp = '0;
        cap = '0;
        io = '0;
        rise = 1'b0;
        fall = 1'b0;
        bsel = '0;
        buf_on = 1'b0;
        // Read: data from the flops, answered one cycle later
        if (cpu_req.sel && !cpu_req.wr) begin
            d.rvalid = 1'b1;
            d.rdata = '0;
            if (ch_idx < 3'(`TCC_NCH)) begin
                unique case (reg_sel)
                    `TCC_SEL_GRA, `TCC_SEL_GRB: d.rdata = q.gr[ch_idx][reg_sel[0]];
                    `TCC_SEL_TCR: d.rdata = {8'h00, q.counter_control[ch_idx]};
                    default: d.rdata = '0;
                endcase
            end else if (ch_idx == `TCC_BUF_BANK) begin
                d.rdata = q.br[reg_sel];
            end
        end
        // Write with byte lanes; unmapped indexes are ignored
        if (cpu_req.sel && cpu_req.wr) begin
            if (ch_idx < 3'(`TCC_NCH)) begin
                unique case (reg_sel)
                    `TCC_SEL_GRA, `TCC_SEL_GRB: begin
                        d.gr[ch_idx][reg_sel[0]] =
                            tcc_merge(q.gr[ch_idx][reg_sel[0]], cpu_req.wdata, cpu_req.be);
                    end
                    `TCC_SEL_TCR: begin
                        // Bit 7 is stored as written and has no effect
                        if (cpu_req.be[0]) d.counter_control[ch_idx] = cpu_req.wdata[7:0];
                    end
                    default: ;
                endcase
            end else if (ch_idx == `TCC_BUF_BANK) begin
                d.br[reg_sel] = tcc_merge(q.br[reg_sel], cpu_req.wdata, cpu_req.be);
            end
        end
        // Compare and capture for every register of every channel
        for (int c = 0; c < `TCC_NCH; c++) begin
            for (int r = 0; r < 2; r++) begin
                io = io_sel[c][r];
                rise = pin_lvl[c][r] && !q.prev[c][r];
                fall = !pin_lvl[c][r] && q.prev[c][r];
                bsel = {c == 4, r[0]};
                buf_on = (c >= `TCC_FIRST_BUF_CH) && function_control[bsel];
                d.prev[c][r] = pin_lvl[c][r];
                // Capture use; PWM modes ignore the select and keep compare use
                if (io[2] && !pwm_mode[c]) begin
                    if (tcc_edge_hit(io[1:0], rise, fall)) begin
                        cap[c][r] = 1'b1;
                        d.gr[c][r] = chan_counter[c];
                        d.flag[c][r] = 1'b1;
                        // Previous capture value moves into the buffer
                        if (buf_on) d.br[bsel] = q.gr[c][r];
                    end
                // Compare checked only on the cycle the counter takes a new count
                end else if (counter_step[c] && chan_counter[c] == q.gr[c][r]) begin
                    cmp[c][r] = 1'b1;
                    d.flag[c][r] = 1'b1;
                    if (buf_on) d.gr[c][r] = q.br[bsel];
                    // Pin level at match
                    unique case (io)
                        `TCC_IO_OUT0: d.lvl[c][r] = 1'b0;
                        `TCC_IO_OUT1: d.lvl[c][r] = 1'b1;
                        `TCC_IO_TOGGLE: begin
                            d.lvl[c][r] = (c == `TCC_STEADY_CH) ? 1'b1 : !q.lvl[c][r];
                        end
                        default: ;
                    endcase
                end
            end
        end
        // Counter clear request per channel
        for (int c = 0; c < `TCC_NCH; c++) begin
            unique case (tcc_clr_e'(q.counter_control[c][`TCC_CCLR_HI:`TCC_CCLR_LO]))
                TCC_CLR_NONE: d.clr[c] = 1'b0;
                TCC_CLR_A: d.clr[c] = cmp[c][0] | cap[c][0];
                TCC_CLR_B: d.clr[c] = cmp[c][1] | cap[c][1];
                TCC_CLR_SYNC: d.clr[c] = sync_clear_in[c];
            endcase
        end
        // Standby holds all state of this block at its reset value; the synchroniser and clock selectors keep running
        if (standby) begin
            d = ST_RST;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // Pin drive only for compare use with output selected
    always_comb begin
        for (int c = 0; c < `TCC_NCH; c++) begin
            for (int r = 0; r < 2; r++) begin
                pin_oe[c][r] = !standby && !io_sel[c][r][2] && (io_sel[c][r] != 3'h0);
            end
        end
    end

    // Registered outputs
    assign pin_out = q.lvl;
    assign match_flag_set = q.flag;
    assign counter_clear = q.clr;
    assign cpu_rdata = q.rdata;
    assign cpu_rvalid = q.rvalid;

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Match on a new count raises the flag one edge later
    AST_CMP_FLAG: assert property (
        (counter_step[0] && !io_sel[0][0][2] && chan_counter[0] == q.gr[0][0] && !standby)
        |=> match_flag_set[0][0])
        else $error("compare match did not raise flag A of channel 0");

    // Capture stores the counter and flags in the same edge
    AST_CAP_STORE: assert property (
        (cap[4][1] && !standby)
        |=> (q.gr[4][1] == $past(chan_counter[4]) && match_flag_set[4][1]))
        else $error("capture did not store counter with flag");

    // Output-one code drives high after the match
    AST_OUT_HIGH: assert property (
        (cmp[0][0] && io_sel[0][0] == `TCC_IO_OUT1 && !standby)
        |=> pin_out[0][0] ##0 $past(pin_oe[0][0]))
        else $error("compare output did not go high");

    // PWM mode never captures
    AST_PWM_NOCAP: assert property (
        pwm_mode[4] |-> cap[4] == 2'h0)
        else $error("capture occurred in PWM mode");

    // Standby turns the pins off and loads all ones into the compare and buffer registers
    AST_STANDBY: assert property (
        standby |-> pin_oe == '0 ##1 (q.gr[2][1] == `TCC_WORD_RESET && q.br[2] == `TCC_WORD_RESET))
        else $error("standby did not reset registers");

    // High byte write leaves the low byte alone
    AST_BYTE_WR: assert property (
        (cpu_req.sel && cpu_req.wr && cpu_req.idx == 5'h00 && cpu_req.be == 2'h2
            && !cmp[0][0] && !cap[0][0] && !standby)
        |=> (q.gr[0][0][7:0] == $past(q.gr[0][0][7:0])
            && q.gr[0][0][15:8] == $past(cpu_req.wdata[15:8])))
        else $error("byte write disturbed the other lane");

    // Buffered compare reloads from the buffer
    AST_BUF_LOAD: assert property (
        (cmp[3][0] && function_control.buffer_en_a_ch3 && !standby)
        |=> q.gr[3][0] == $past(q.br[0]))
        else $error("buffer not copied at compare match");

    // Buffered capture keeps the old value
    AST_BUF_CAP: assert property (
        (cap[4][1] && function_control.buffer_en_b_ch4 && !standby)
        |=> q.br[3] == $past(q.gr[4][1]))
        else $error("old capture value not moved to buffer");

    // Clear on register A event
    AST_CLR_A: assert property (
        ((cmp[0][0] || cap[0][0]) && q.counter_control[0][6:5] == 2'h1 && !standby)
        |=> counter_clear[0])
        else $error("clear on register A event missing");

    // Synchronized clear follows the partner
    AST_CLR_SYNC: assert property (
        (q.counter_control[2][6:5] == 2'b11 && sync_clear_in[2] && !standby) |=> counter_clear[2])
        else $error("synchronized clear missing");

    // Undivided internal clock counts on every cycle; three cycles cover the reset edge
    AST_TICK_DIV1: assert property (
        (q.counter_control[0][2:0] == 3'h0) [*3] |-> count_tick[0])
        else $error("undivided clock missed a count");

    // Phase counting silences channel 2 count requests
    AST_PHASE: assert property (
        phase_mode_ch2 [*2] |-> !count_tick[2])
        else $error("count request in phase counting mode");

    // Main scenarios
    CV_BUF_CMP: cover property (cmp[3][0] && function_control.buffer_en_a_ch3);
    CV_BUF_CAP: cover property (cap[4][1] && function_control.buffer_en_b_ch4);
    CV_SYNC_CLR: cover property (counter_clear[2]);

endmodule : tcc_top

// ### test/tcc_pin_model.sv
// Pin-side model: outside capture drivers and the resolved pin wires
`timescale 1ns/100ps
module tcc_pin_model (
    // Design side of the pins
    input wire logic [4:0][1:0] pin_out,
    input wire logic [4:0][1:0] pin_oe,
    // Levels that outside circuits put on the pins
    input wire logic [4:0][1:0] drv_lvl,
    // Resolved wire levels fed back to the design
    output logic [4:0][1:0] pin_in
);
    // A driven pin shows the design's level, otherwise the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_lvl);
endmodule : tcc_pin_model

// ### test/test_tcc_top.sv
// Self-checking bench for the compare/capture block
`timescale 1ns/100ps
module test_tcc_top
    import tcc_pkg::*;
();
    // Design connections
    logic mclk, rst_n, standby, cpu_rvalid, phase_mode_ch2;
    tcc_bus_s cpu_req;
    logic [15:0] cpu_rdata;
    tcc_word_t [4:0] chan_counter;
    logic [4:0] counter_step, pwm_mode, sync_clear_in, counter_clear, count_tick;
    logic [4:0][1:0][2:0] io_sel;
    tcc_fn_s function_control;
    logic [4:0][1:0] pin_in, pin_out, pin_oe, pin_drv, match_flag_set;
    logic [3:0] ext_clock_in;
    // Bench bookkeeping
    int errors, checks_done, t;
    logic [2:0] codes [4] = '{3'h2, 3'h1, 3'h3, 3'h3};
    logic lv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    tcc_top i_tcc_top (.mclk(mclk), .rst_n(rst_n), .standby(standby), .cpu_req(cpu_req),
        .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .chan_counter(chan_counter),
        .counter_step(counter_step), .io_sel(io_sel), .pwm_mode(pwm_mode),
        .phase_mode_ch2(phase_mode_ch2), .function_control(function_control),
        .sync_clear_in(sync_clear_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_clock_in(ext_clock_in), .match_flag_set(match_flag_set),
        .counter_clear(counter_clear), .count_tick(count_tick));
    tcc_pin_model i_tcc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .drv_lvl(pin_drv),
        .pin_in(pin_in));

    // Clock at 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Compare a seen value with the expected one
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Print counts and verdict, then stop
    task automatic final_report;
        $display("COUNTS checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // Register write, taken one edge after launch
    task automatic wr(input logic [4:0] idx, input logic [1:0] be, input tcc_word_t d);
        @(posedge mclk);
        cpu_req <= {1'b1, 1'b1, idx, be, d};
        @(posedge mclk);
        cpu_req.sel <= 1'b0;
    endtask : wr

    // Register read; answer marked by a one-cycle valid
    task automatic rd(input logic [4:0] idx, input tcc_word_t exp);
        @(posedge mclk);
        cpu_req <= {1'b1, 1'b0, idx, 2'h3, 16'h0000};
        @(posedge mclk);
        cpu_req.sel <= 1'b0;
        #1;
        check({cpu_rvalid, cpu_rdata}, {1'b1, exp});
    endtask : rd

    // Present one count to a channel, with or without its step strobe
    task automatic step(input int c, input tcc_word_t v, input logic s);
        @(posedge mclk);
        chan_counter[c] <= v;
        counter_step[c] <= s;
        @(posedge mclk);
        counter_step[c] <= 1'b0;
        #1;
    endtask : step

    // Wait a bounded time for a capture flag
    task automatic wait_cap(input int c, input int s, input logic hit);
        int n;
        n = 0;
        #1;
        while (n < 10 && match_flag_set[c][s] !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check({16'h0, match_flag_set[c][s]}, {16'h0, hit});
        if (hit && n == 10) final_report();
    endtask : wait_cap

    // Count ticks of a channel; pulse the masked external clocks four times
    task automatic count_ticks(input int c, input int n, input logic [3:0] ext);
        t = 0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            ext_clock_in <= ext & {4{(i < n - 12) && i[2]}};
            #1;
            t += int'(count_tick[c]);
        end
    endtask : count_ticks

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        final_report();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0; standby = 1'b0; cpu_req = '0; chan_counter = '0; counter_step = '0;
        io_sel = '0; pwm_mode = '0; phase_mode_ch2 = 1'b0; function_control = '0;
        sync_clear_in = '0; pin_drv = '0; ext_clock_in = '0; errors = 0; checks_done = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        // Reset values of every register, and an unmapped index
        for (int c = 0; c < 5; c++) begin
            rd(5'(c * 4), 16'hffff);
            rd(5'(c * 4 + 1), 16'hffff);
            rd(5'(c * 4 + 2), 16'h0080);
        end
        for (int b = 20; b < 24; b++) rd(5'(b), 16'hffff);
        rd(5'd24, 16'h0000);
        $display("TEST reset_values done");
        // Word and byte lane writes
        wr(5'd0, 2'h3, 16'h1234);
        wr(5'd0, 2'h1, 16'hff10);
        rd(5'd0, 16'h1210);
        wr(5'd0, 2'h2, 16'h00aa);
        rd(5'd0, 16'h0010);
        wr(5'd20, 2'h2, 16'h5500);
        rd(5'd20, 16'h55ff);
        $display("TEST byte_access done");
        // Compare output codes with clear on register A
        wr(5'd2, 2'h1, 16'h0020);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            io_sel[0][0] <= codes[i];
            step(0, 16'h0010, 1'b1);
            check({16'h0, match_flag_set[0][0]}, 17'h1);
            check({15'h0, pin_out[0][0], pin_oe[0][0]}, {15'h0, lv[i], 1'b1});
            check({16'h0, counter_clear[0]}, 17'h1);
        end
        step(0, 16'h0011, 1'b1);
        check({16'h0, match_flag_set[0][0]}, 17'h0);
        step(0, 16'h0010, 1'b0);
        check({16'h0, match_flag_set[0][0]}, 17'h0);
        $display("TEST compare done");
        // Buffered compare on channel 3 A only
        @(posedge mclk);
        function_control.buffer_en_a_ch3 <= 1'b1;
        wr(5'd20, 2'h3, 16'h0055);
        wr(5'd12, 2'h3, 16'h0030);
        wr(5'd13, 2'h3, 16'h0030);
        step(3, 16'h0030, 1'b1);
        check({16'h0, match_flag_set[3][1]}, 17'h1);
        rd(5'd12, 16'h0055);
        rd(5'd13, 16'h0030);
        $display("TEST buffer_compare done");
        // Buffered capture on channel 4 B, rising, falling, then both edges, then PWM
        @(posedge mclk);
        io_sel[4][1] <= 3'h4;
        function_control.buffer_en_b_ch4 <= 1'b1;
        wr(5'd17, 2'h3, 16'h0077);
        wr(5'd18, 2'h1, 16'h0040);
        @(posedge mclk);
        chan_counter[4] <= 16'h0abc;
        pin_drv[4][1] <= 1'b1;
        wait_cap(4, 1, 1'b1);
        check({16'h0, counter_clear[4]}, 17'h1);
        rd(5'd17, 16'h0abc);
        rd(5'd23, 16'h0077);
        @(posedge mclk);
        io_sel[4][1] <= 3'h5;
        chan_counter[4] <= 16'h0def;
        pin_drv[4][1] <= 1'b0;
        wait_cap(4, 1, 1'b1);
        rd(5'd23, 16'h0abc);
        @(posedge mclk);
        io_sel[4][1] <= 3'h6;
        chan_counter[4] <= 16'h0123;
        pin_drv[4][1] <= 1'b1;
        wait_cap(4, 1, 1'b1);
        @(posedge mclk);
        pwm_mode[4] <= 1'b1;
        pin_drv[4][1] <= 1'b0;
        wait_cap(4, 1, 1'b0);
        rd(5'd17, 16'h0123);
        $display("TEST capture done");
        // Synchronized clear on channel 2
        wr(5'd10, 2'h1, 16'h0060);
        @(posedge mclk);
        sync_clear_in[2] <= 1'b1;
        @(posedge mclk);
        sync_clear_in[2] <= 1'b0;
        #1;
        check({16'h0, counter_clear[2]}, 17'h1);
        $display("TEST sync_clear done");
        // Internal prescaler codes and external edge choices on channel 1
        for (int p = 0; p < 4; p++) begin
            wr(5'd6, 2'h1, 16'(p));
            count_ticks(1, 8, 4'h0);
            check(17'(t), 17'(8 >> p));
        end
        // External clocks A to D, each driven alone, edge fields rise, fall, both, rise
        for (int e = 0; e < 4; e++) begin
            wr(5'd6, 2'h1, 16'(((e % 3) << 3) | (4 + e)));
            count_ticks(1, 44, 4'(1 << e));
            check(17'(t), 17'((e == 2) ? 8 : 4));
        end
        @(posedge mclk);
        phase_mode_ch2 <= 1'b1;
        wr(5'd10, 2'h1, 16'h0000);
        count_ticks(2, 8, 4'h0);
        check(17'(t), 17'h0);
        $display("TEST count_clock done");
        // Standby resets state and drops pin drive; writes lost
        wr(5'd0, 2'h3, 16'h4321);
        @(posedge mclk);
        standby <= 1'b1;
        @(posedge mclk);
        #1;
        check({15'h0, pin_oe[0][0], pin_out[0][0]}, 17'h0);
        wr(5'd1, 2'h3, 16'h1111);
        @(posedge mclk);
        standby <= 1'b0;
        rd(5'd0, 16'hffff);
        rd(5'd1, 16'hffff);
        rd(5'd20, 16'hffff);
        rd(5'd6, 16'h0080);
        $display("TEST standby done");
        final_report();
    end
endmodule : test_tcc_top
